// >>> verilog/aea_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the energy accumulator
// Assumes: byte addressed APB, one 32-bit word per register
// Notes:   printed offsets are register indices, byte address is four times the index
`ifndef AEA_CONSTS_SVH
`define AEA_CONSTS_SVH
`define AEA_IDX_WAVE_SEL     8'h0D
`define AEA_IDX_ACC_MODE     8'h0F
`define AEA_IDX_IRQ_EN3      8'hDB
`define AEA_IDX_ENERGY       8'hE0
`define AEA_IDX_ENERGY_RC    8'hE1
`define AEA_IDX_DIVIDER      8'hE2
`define AEA_IDX_GAIN         8'hE3
`define AEA_IDX_NOLOAD       8'hE4
`define AEA_IDX_STATUS       8'hE5
`define AEA_IDX_IRQ_EN1      8'hE6
`define AEA_ACC_POS_BIT      0
`define AEA_ACC_ABS_BIT      1
`define AEA_ACC_SIGNPOL_BIT  2
`define AEA_WAVEFORM_SAMPLE_ENABLE_BIT         0
`define AEA_ST_HALF_BIT      0
`define AEA_ST_OVF_BIT       1
`define AEA_ST_UNF_BIT       2
`define AEA_ST_SIGN_BIT      3
`define AEA_ST_NOLOAD_BIT    4
`define AEA_RST_BYTE         8'h00
`define AEA_RST_GAIN         12'h000
`define AEA_STEP_CYCLES      3'h5
`define AEA_NL_THR1          24'h00007E
`define AEA_NL_THR2          24'h00003F
`define AEA_NL_THR3          24'h00001F
`define AEA_PULSE_BIT        30
`define AEA_PULSE_LEN        16'h0100
`endif

// >>> verilog/aea_pkg.sv
// Purpose: types shared by the energy accumulator
// Assumes: nothing
// Notes:   constants live in aea_consts.svh
package aea_pkg;
  typedef enum logic [1:0] {
    AEA_SIGNED   = 2'b00,
    AEA_POSITIVE = 2'b01,
    AEA_ABSOLUTE = 2'b11
  } aea_mode_e;
  typedef struct packed {
    logic        half;
    logic        ovf;
    logic        unf;
    logic        sign;
    logic        noload;
  } aea_event_s;
  typedef logic [48:0] aea_acc_t;
endpackage

// >>> verilog/aea_energy_accum.sv
// Purpose: active energy accumulator with APB register access
// Assumes: power sample is a signed 24-bit word on sys_clk, no interrupt logic here
// Notes:   event flags are sticky, software clears by writing one; set wins over clear
// Summary of operation
// - add power sample into 49-bit accumulator at each accumulation
// - energy register shows accumulator top 24 bits
// - one accumulation step every five clocks
// - accumulate once per divider steps, zero means one
// - divider stretches overflow time by its value
// - largest positive accumulator value two to 48 minus one
// - read-clear register returns energy then clears top
// - both mode bits clear gives signed accumulation
// - both mode bits set gives positive-only
// - positive-only ignores all negative power
// - absolute mode adds magnitude above no-load
// - sign detection always runs, no-load detection unless its level code is 00
// - positive overflow wraps to full-scale negative
// - negative underflow wraps to full-scale positive
// - flag half-full, overflow and underflow events
// - power readable through waveform tap when enabled
// - pulse output rate tracks calibrated power
// - pulse output follows positive-only and absolute modes; signed mode pulses on positive power only
// - pulse output is active low
// - gain-calibrated power feeds the accumulator
// - below no-load threshold no accumulation, flag set
// - no-load level code selects threshold or off
// - sign flag edge chosen by polarity bit
`timescale 1ns/1ns
`include "aea_consts.svh"
module aea_energy_accum (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [23:0] power_sample,
  output logic [23:0]      waveform_data,
  output logic             energy_pulse_out_n,
  output logic             no_load_flag
);
  logic [7:0]  waveform_source_select;
  logic [7:0]  accumulation_mode_control;
  logic [7:0]  measurement_irq_enable_three;
  logic [7:0]  measurement_irq_enable_one;
  logic [7:0]  energy_divider;
  logic [11:0] power_gain_trim;
  logic [1:0]  no_load_level_control;
  aea_pkg::aea_event_s flags;
  aea_pkg::aea_acc_t   acc;
  logic [2:0]  step_cnt;
  logic        step;
  logic [7:0]  div_cnt;
  logic        prev_neg;
  logic [31:0] pulse_acc;
  logic [15:0] pulse_cnt;
  logic        access;
  logic        rd_clear;
  logic [9:0]  idx;
  logic [36:0] gained;
  logic signed [24:0] cal_power;
  logic [24:0] mag;
  logic        below_nl;
  logic [23:0] nl_thr;
  aea_pkg::aea_mode_e mode;
  logic signed [24:0] contrib;
  aea_pkg::aea_acc_t  next_acc;
  logic [23:0] cur_top;
  logic [23:0] new_top;
  logic        div_done;

  // register index from a word aligned byte address
  // the top two index bits must be zero, so no register is mirrored higher up
  function automatic logic hit(input logic [9:0] a, input logic [7:0] i);
    hit = (a == {2'b00, i});
  endfunction

  // combined cycle of an APB access phase
  // a read-clear acts only in the access cycle, never twice for one transfer
  assign access   = psel && penable;
  assign idx      = paddr[11:2];
  assign rd_clear = access && !pwrite && hit(idx, `AEA_IDX_ENERGY_RC);

  // full precision product before the shift, so a zero trim passes the sample unchanged
  // gain trim: power * (1 + gain/4096), signed
  always_comb
  begin
    gained    = 37'($signed(power_sample)) * 37'($signed({{1{1'b0}}, 13'h1000}) +
                37'($signed(power_gain_trim)));
    cal_power = 25'($signed(gained) >>> 12);
    mag       = cal_power[24] ? 25'(-cal_power) : cal_power;
  end

  // no-load threshold selection, code 00 disables detection
  // thresholds compare against the calibrated magnitude, the value that would be summed
  always_comb
  begin
    case (no_load_level_control)
      2'b01:   nl_thr = `AEA_NL_THR1;
      2'b10:   nl_thr = `AEA_NL_THR2;
      2'b11:   nl_thr = `AEA_NL_THR3;
      default: nl_thr = 24'h000000;
    endcase
    below_nl = (no_load_level_control != 2'b00) && (mag < {1'b0, nl_thr});
  end

  // mode decode: positive-only wins when both bits set
  // every mode honours the no-load gate, so creep below the threshold never counts
  always_comb
  begin
    if (accumulation_mode_control[`AEA_ACC_POS_BIT])
      mode = aea_pkg::AEA_POSITIVE;
    else if (accumulation_mode_control[`AEA_ACC_ABS_BIT])
      mode = aea_pkg::AEA_ABSOLUTE;
    else
      mode = aea_pkg::AEA_SIGNED;
    case (mode)
      aea_pkg::AEA_POSITIVE: contrib = (cal_power[24] || below_nl) ? 25'h0 : cal_power;
      aea_pkg::AEA_ABSOLUTE: contrib = below_nl ? 25'h0 : mag;
      default:               contrib = below_nl ? 25'h0 : cal_power;
    endcase
  end

  // divider zero acts as one; a step accumulates once per divider count
  // skipping steps instead of dividing each sample keeps every fraction of a sample,
  // traded against a coarser time granularity of the sum
  assign div_done = (div_cnt + 8'h01 >= energy_divider);
  always_comb
  begin
    next_acc = acc + aea_pkg::aea_acc_t'($signed(contrib)); // wraps at 49 bits
    cur_top  = acc[48:25];
    new_top  = next_acc[48:25];
  end

  // step strobe every fifth clock; counter chosen over a divided clock to stay single domain
  // the strobe is decoded from the counter and only gates registers, never a pin
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      step_cnt <= 3'h0;
    else if (step_cnt == `AEA_STEP_CYCLES - 3'h1)
      step_cnt <= 3'h0;
    else
      step_cnt <= step_cnt + 3'h1;
  end
  assign step = (step_cnt == `AEA_STEP_CYCLES - 3'h1);

  // divider prescaler
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      div_cnt <= 8'h00;
    else if (step)
      div_cnt <= div_done ? 8'h00 : div_cnt + 8'h01;
  end

  // accumulator; a read-clear drops the top 24 bits, keeping the fraction
  // a step that lands on the clearing edge keeps its fraction, so no sample is lost
  // limitation: a carry into the top bits on that same edge goes with the clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      acc <= 49'h0;
    else if (rd_clear)
      acc <= {24'h000000, (step && div_done) ? next_acc[24:0] : acc[24:0]};
    else if (step && div_done)
      acc <= next_acc; // natural wrap
  end

  // sticky event flags; hardware set wins over software write-one clear
  // each flag clears through its own status bit; the packed struct order runs
  // opposite to the status word, so a whole-word mask would hit the wrong flag
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flags    <= '0;
      prev_neg <= 1'b0;
    end
    else
    begin
      if (access && pwrite && hit(idx, `AEA_IDX_STATUS))
      begin
        flags.half   <= flags.half & ~pwdata[`AEA_ST_HALF_BIT];
        flags.ovf    <= flags.ovf & ~pwdata[`AEA_ST_OVF_BIT];
        flags.unf    <= flags.unf & ~pwdata[`AEA_ST_UNF_BIT];
        flags.sign   <= flags.sign & ~pwdata[`AEA_ST_SIGN_BIT];
        flags.noload <= flags.noload & ~pwdata[`AEA_ST_NOLOAD_BIT];
      end
      if (step && div_done && !rd_clear)
      begin
        if (!cur_top[23] && !cur_top[22] && new_top[22] && !new_top[23])
          flags.half <= 1'b1; // positive half
        if (cur_top[23] && cur_top[22] && !new_top[22] && new_top[23])
          flags.half <= 1'b1; // negative half
        if (!cur_top[23] && new_top[23] && !contrib[24])
          flags.ovf <= 1'b1;
        if (cur_top[23] && !new_top[23] && contrib[24])
          flags.unf <= 1'b1;
      end
      if (step)
      begin
        prev_neg <= cal_power[24];
        if (accumulation_mode_control[`AEA_ACC_SIGNPOL_BIT] ? (prev_neg && !cal_power[24])
            : (!prev_neg && cal_power[24]))
          flags.sign <= 1'b1;
        if (below_nl)
          flags.noload <= 1'b1;
      end
    end
  end

  // pulse output: fixed-length low pulse each time the sum of non-negative mode-shaped contributions passes a bit boundary
  // limitation: a second crossing inside a running pulse restarts the low time
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pulse_acc          <= 32'h0;
      pulse_cnt          <= 16'h0;
      energy_pulse_out_n <= 1'b1;
    end
    else
    begin
      if (step && !contrib[24])
        pulse_acc <= pulse_acc + 32'($signed(contrib));
      if (step && !contrib[24] && (pulse_acc[`AEA_PULSE_BIT] !=
          pulse_acc_next_bit(pulse_acc, contrib)))
        pulse_cnt <= `AEA_PULSE_LEN;
      else if (pulse_cnt != 16'h0)
        pulse_cnt <= pulse_cnt - 16'h1;
      energy_pulse_out_n <= (pulse_cnt == 16'h0);
    end
  end

  // bit of the pulse accumulator after adding a contribution
  function automatic logic pulse_acc_next_bit(input logic [31:0] a, input logic [24:0] c);
    logic [31:0] s;
    s = a + 32'($signed(c));
    pulse_acc_next_bit = s[`AEA_PULSE_BIT];
  endfunction

  // waveform tap and no-load flag mirror
  // the tap holds the last sample taken and does not follow the input between steps
  // a zero source select parks it, so software sees no stray updates
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      waveform_data <= 24'h0;
      no_load_flag  <= 1'b0;
    end
    else
    begin
      if (step && measurement_irq_enable_three[`AEA_WAVEFORM_SAMPLE_ENABLE_BIT] &&
          waveform_source_select != 8'h00)
        waveform_data <= cal_power[23:0];
      no_load_flag <= below_nl;
    end
  end

  // software writable registers, taken in the access phase
  // a write to an unmapped or read-only index changes nothing
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      waveform_source_select       <= `AEA_RST_BYTE;
      accumulation_mode_control    <= `AEA_RST_BYTE;
      measurement_irq_enable_three <= `AEA_RST_BYTE;
      measurement_irq_enable_one   <= `AEA_RST_BYTE;
      energy_divider               <= `AEA_RST_BYTE;
      power_gain_trim              <= `AEA_RST_GAIN;
      no_load_level_control        <= 2'b00;
    end
    else if (access && pwrite)
    begin
      if (hit(idx, `AEA_IDX_WAVE_SEL))
        waveform_source_select <= pwdata[7:0];
      if (hit(idx, `AEA_IDX_ACC_MODE))
        accumulation_mode_control <= pwdata[7:0];
      if (hit(idx, `AEA_IDX_IRQ_EN3))
        measurement_irq_enable_three <= pwdata[7:0];
      if (hit(idx, `AEA_IDX_IRQ_EN1))
        measurement_irq_enable_one <= pwdata[7:0];
      if (hit(idx, `AEA_IDX_DIVIDER))
        energy_divider <= pwdata[7:0];
      if (hit(idx, `AEA_IDX_GAIN))
        power_gain_trim <= pwdata[11:0];
      if (hit(idx, `AEA_IDX_NOLOAD))
        no_load_level_control <= pwdata[1:0];
    end
  end

  // read path; unmapped addresses answer with pslverr
  // read data is latched in the setup cycle so it stands through the whole access
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable)
      begin
        if (hit(idx, `AEA_IDX_WAVE_SEL))
          prdata <= {24'h0, waveform_source_select};
        else if (hit(idx, `AEA_IDX_ACC_MODE))
          prdata <= {24'h0, accumulation_mode_control};
        else if (hit(idx, `AEA_IDX_IRQ_EN3))
          prdata <= {24'h0, measurement_irq_enable_three};
        else if (hit(idx, `AEA_IDX_IRQ_EN1))
          prdata <= {24'h0, measurement_irq_enable_one};
        else if (hit(idx, `AEA_IDX_ENERGY) || hit(idx, `AEA_IDX_ENERGY_RC))
          prdata <= {8'h0, acc[48:25]};
        else if (hit(idx, `AEA_IDX_DIVIDER))
          prdata <= {24'h0, energy_divider};
        else if (hit(idx, `AEA_IDX_GAIN))
          prdata <= {20'h0, power_gain_trim};
        else if (hit(idx, `AEA_IDX_NOLOAD))
          prdata <= {30'h0, no_load_level_control};
        else if (hit(idx, `AEA_IDX_STATUS))
          prdata <= {27'h0, flags.noload, flags.sign, flags.unf, flags.ovf, flags.half};
        else
          pslverr <= 1'b1;
      end
    end
  end
endmodule // aea_energy_accum

// >>> tb/aea_mcu_model.sv
// Purpose: microcontroller side, an apb master reaching the registers
// Assumes: one transfer at a time, byte address is four times the index
// Notes:   waits for pready without limit, the bench watchdog ends a hang
`timescale 1ns/1ns
module aea_mcu_model (
  input  wire logic        sys_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // bus idle from time zero
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // setup, then access held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'h0, i, 2'h0};
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // aea_mcu_model

// >>> tb/aea_energy_accum_properties.sv
// Purpose: bus answer and pulse timing checks for the energy accumulator
// Assumes: byte address is four times the register index
// Notes:   sees the top ports only
`timescale 1ns/1ns
`include "aea_consts.svh"
module aea_energy_accum_properties (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        energy_pulse_out_n
);
  logic [8:0] low_cnt;
  logic       mapped;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // decode of the mapped indices, address is held through the access
  assign mapped = paddr[11:10] == 2'h0 && (paddr[9:2] == `AEA_IDX_WAVE_SEL
    || paddr[9:2] == `AEA_IDX_ACC_MODE || paddr[9:2] == `AEA_IDX_IRQ_EN3
    || (paddr[9:2] >= `AEA_IDX_ENERGY && paddr[9:2] <= `AEA_IDX_IRQ_EN1));
  // cycles spent low in the current pulse
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      low_cnt <= 9'h000;
    else if (energy_pulse_out_n)
      low_cnt <= 9'h000;
    else
      low_cnt <= low_cnt + 9'h001;
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_source: assert property (pready |-> penable && $past(psel && !penable))
    else $error("answer without setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped index not refused");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("mapped index refused");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused read carries data");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00)
    else $error("upper read byte not zero");
  a_pulse_len: assert property ($rose(energy_pulse_out_n) |-> low_cnt == 9'h100)
    else $error("pulse low length wrong");
  a_pulse_bound: assert property (!energy_pulse_out_n |-> low_cnt < 9'h100)
    else $error("pulse low too long");
endmodule // aea_energy_accum_properties
bind aea_energy_accum aea_energy_accum_properties PROPS (.sys_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pready, .prdata, .pslverr, .energy_pulse_out_n);

// >>> tb/tb_active_energy_accumulator.sv
// Purpose: self-checking bench for the energy accumulator
// Assumes: gain stays zero, so calibrated power equals the sample
// Notes:   model keeps the 49-bit sum, one accumulation of slack per read
`timescale 1ns/1ns
`include "aea_consts.svh"
module tb_active_energy_accumulator;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [23:0] power_sample = 24'h000000;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] waveform_data;
  logic        energy_pulse_out_n, no_load_flag;
  logic        pulse_seen = 1'b0;
  int          failures = 0, n_tests = 0, md = 0, dv = 0, nl = 0, v;
  longint      m = 0;
  always #5 sys_clk = ~sys_clk;
  // remember that a pulse went out at all
  always @(negedge energy_pulse_out_n) pulse_seen = 1'b1;
  aea_mcu_model MCU (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr);
  aea_energy_accum DUT (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .power_sample, .waveform_data, .energy_pulse_out_n, .no_load_flag);
  // tol lets one accumulation of step phase slip past
  task automatic check(input string nm, input logic [31:0] seen, exp, input int tol);
    logic [23:0] d;
    d = seen[23:0] - exp[23:0];
    n_tests++;
    if (seen !== exp && !(tol > 0 && ^seen !== 1'bx && (d <= 24'h1 || d == 24'hFFFFFF)))
    begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // hold one sample for k steps, then compare energy with the model
  task automatic run(input int s, input int k);
    int a;
    int mag;
    mag = s < 0 ? -s : s;
    a = (md == 2) ? mag : (md[0] && s < 0) ? 0 : s;
    if (nl != 0 && mag < 'h7E)
      a = 0;
    power_sample <= s[23:0];
    repeat (5 * k) @(posedge sys_clk);
    check("wave", waveform_data, s[23:0], 0);
    check("noload", no_load_flag, nl != 0 && mag < 'h7E, 0);
    power_sample <= 24'h000000;
    m += longint'(a) * (k / (dv != 0 ? dv : 1));
    MCU.xfer(1'b0, `AEA_IDX_ENERGY, 32'h0, rd, err);
    check("energy", rd, m[48:25], 1);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    logic [7:0] ix [3];
    ix = '{`AEA_IDX_ACC_MODE, `AEA_IDX_DIVIDER, `AEA_IDX_ENERGY};
    v = $urandom(52320);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    check("pulse idle", energy_pulse_out_n, 1, 0);
    foreach (ix[i])
    begin
      MCU.xfer(1'b0, ix[i], 32'h0, rd, err);
      check("reset value", rd, 0, 0);
    end
    MCU.xfer(1'b0, 8'h00, 32'h0, rd, err);
    check("unmapped", err, 1, 0);
    v = $urandom & 'hFF;
    MCU.xfer(1'b1, `AEA_IDX_DIVIDER, v, rd, err);
    MCU.xfer(1'b0, `AEA_IDX_DIVIDER, 32'h0, rd, err);
    check("divider", rd, v, 0);
    MCU.xfer(1'b1, `AEA_IDX_DIVIDER, 32'h0, rd, err);
    MCU.xfer(1'b1, `AEA_IDX_WAVE_SEL, 32'h1, rd, err);
    MCU.xfer(1'b1, `AEA_IDX_IRQ_EN3, 32'h1, rd, err);
    v = 'h400000 + ($urandom & 'h3FFFFF);
    run(v, 200);
    run(-v, 300);
    // positive-only, absolute, both bits set
    for (int j = 0; j < 3; j++)
    begin
      md = j + 1;
      MCU.xfer(1'b1, `AEA_IDX_ACC_MODE, md, rd, err);
      run(-v, 100);
      run(v, 50);
    end
    md = 0;
    MCU.xfer(1'b1, `AEA_IDX_ACC_MODE, 32'h0, rd, err);
    MCU.xfer(1'b0, `AEA_IDX_ENERGY_RC, 32'h0, rd, err);
    check("read clear", rd, m[48:25], 1);
    m &= 64'h1FFFFFF;
    MCU.xfer(1'b0, `AEA_IDX_ENERGY, 32'h0, rd, err);
    check("cleared", rd, 0, 0);
    nl = 1;
    MCU.xfer(1'b1, `AEA_IDX_NOLOAD, 32'h1, rd, err);
    run(-'h10, 10);
    MCU.xfer(1'b0, `AEA_IDX_STATUS, 32'h0, rd, err);
    check("status", rd, 32'h18, 0);
    MCU.xfer(1'b1, `AEA_IDX_STATUS, 32'h8, rd, err);
    MCU.xfer(1'b0, `AEA_IDX_STATUS, 32'h0, rd, err);
    check("status clear", rd, 32'h10, 0);
    run(v, 600);
    check("pulse seen", pulse_seen, 1, 0);
    dv = 4;
    MCU.xfer(1'b1, `AEA_IDX_DIVIDER, 32'h4, rd, err);
    run(v, 400);
    conclude();
  end
  // cuts a hang short, the run needs about 9900 cycles
  initial
  begin
    #500000;
    failures++;
    conclude();
  end
endmodule // tb_active_energy_accumulator
